// ===== include/lcd_pkg.sv
package lcd_pkg;

    // display memory geometry
    localparam int       NUM_COLUMNS   = 80;
    localparam logic [6:0] LAST_COLUMN = 7'h4F;
    localparam int       NUM_PAGES     = 4;
    localparam int       NUM_COMMONS   = 16;
    localparam int       MEM_DEPTH     = NUM_PAGES * NUM_COLUMNS;
    localparam int       MEM_AW        = 9;
    localparam logic [8:0] PAGE_STRIDE = 9'h050;

    // command encodings
    localparam logic [7:0] START_MASK   = 8'hE0;
    localparam logic [7:0] START_CODE   = 8'hC0;
    localparam logic [7:0] PAGE_MASK    = 8'hFC;
    localparam logic [7:0] PAGE_CODE    = 8'hB8;
    localparam logic [7:0] COLUMN_MASK  = 8'h80;
    localparam logic [7:0] COLUMN_CODE  = 8'h00;
    localparam logic [7:0] ONE_BIT_MASK = 8'hFE;
    localparam logic [7:0] MAP_CODE     = 8'hA0;
    localparam logic [7:0] STATIC_CODE  = 8'hA4;
    localparam logic [7:0] DUTY_CODE    = 8'hA8;
    localparam logic [7:0] DISPLAY_CODE = 8'hAE;

    // reset values
    localparam logic [4:0] START_RST   = 5'h00;
    localparam logic [1:0] PAGE_RST    = 2'h3;
    localparam logic [6:0] COLUMN_RST  = 7'h00;
    localparam logic       MAP_RST     = 1'b0;
    localparam logic       STATIC_RST  = 1'b0;
    localparam logic       DUTY_RST    = 1'b1;
    localparam logic       DISPLAY_RST = 1'b0;

    // status byte layout
    localparam int ST_BUSY_BIT  = 7;
    localparam int ST_MAP_BIT   = 6;
    localparam int ST_OFF_BIT   = 5;
    localparam int ST_RESET_BIT = 4;

    // row scan timing
    localparam int ROW_PERIOD_NS   = 4000;
    localparam int CLK_PERIOD_NS   = 4;
    localparam logic [11:0] ROW_TICK_CYCLES = 12'(ROW_PERIOD_NS / CLK_PERIOD_NS);

    typedef struct packed {
        logic       chip_enable;
        logic       command_data_select;
        logic       enable_read_strobe;
        logic       read_write_select;
        logic [7:0] data;
    } host_pins_s;

    typedef struct packed {
        logic [4:0] first_row_pointer;
        logic [1:0] memory_page_pointer;
        logic [6:0] memory_column_pointer;
        logic       segment_order_select;
        logic       low_power_hold;
        logic       duty_32;
        logic       display_on;
    } config_s;

endpackage

// ===== design/display_ram.sv
`timescale 1ns/1ps
module display_ram
    import lcd_pkg::*;
(
    input  wire logic              clk,
    input  wire logic [1:0]        a_page,
    input  wire logic [6:0]        a_column,
    input  wire logic              a_write,
    input  wire logic [7:0]        a_wdata,
    output logic      [7:0]        a_rdata,
    input  wire logic [1:0]        b_page,
    input  wire logic [6:0]        b_column,
    output logic      [7:0]        b_rdata
);

    logic [7:0]        mem [MEM_DEPTH];
    logic [MEM_AW-1:0] a_index;
    logic [MEM_AW-1:0] b_index;

    // page times 80 plus column, no holes in the array
    assign a_index = MEM_AW'(a_page * PAGE_STRIDE) + MEM_AW'(a_column);
    assign b_index = MEM_AW'(b_page * PAGE_STRIDE) + MEM_AW'(b_column);

    always_ff @(posedge clk) begin
        if (a_write) begin
            mem[a_index] <= a_wdata;
        end
        a_rdata <= mem[a_index];
        b_rdata <= mem[b_index];
    end

endmodule

// ===== design/lcd_addressing_command_decoder.sv
// Overview of operation
// (R1) host writes commands with select low, read strobe high, write select low.
// (R2) a 5-bit start row picks the memory row shown on the first common.
// (R3) later commons take following rows, wrapping in a 32 or 16 row block.
// (R4) codes C0..DF load their low five bits into the start row pointer.
// (R5) memory is four pages of eight rows by 80 byte columns.
// (R6) host sets the page pointer before touching display memory.
// (R7) codes B8..BB load their low two bits into the page pointer.
// (R8) column pointer steps by one after every finished memory read or write.
// (R9) column 79 steps back to zero.
// (R10) codes with bit 7 clear load the column pointer, legal 0..79.
// (R11) reversed order sends column 79 to the first segment, else column 0.
// (R12) codes A0 and A1 store bit 0 as the segment order select.
// (R13) low power hold stops the internal clock and suspends logic switching.
// (R14) display off with hold on puts all drive outputs at supply, keeps state.
// (R15) codes A4 and A5 store bit 0 as the low power hold.
// (R16) host should also switch off the external bias transistor in hold.
// (R17) only the first sixteen commons are driven by this chip.
// (R18) duty bit set gives a 32 row block, clear gives 16.
// (R19) status read gives busy, mapping, display off, reset high, zeros low.
// (R20) unknown command codes change nothing.
// (R21) column stepping follows data transfers only, never commands.
`timescale 1ns/1ps
module lcd_addressing_command_decoder
    import lcd_pkg::*;
(
    input  wire logic                   clk,
    input  wire logic                   rst_b,
    input  wire host_pins_s             host_in,
    output logic      [7:0]             data_out,
    output logic                        data_oe,
    output logic      [NUM_COMMONS-1:0] common_out,
    output logic      [NUM_COLUMNS-1:0] segment_out,
    output logic                        outputs_at_supply,
    output logic                        oscillator_output_pin,
    output logic                        oscillator_output_oe,
    output logic                        low_power_active
);

    typedef enum logic [1:0] {
        SCAN_WAIT,
        SCAN_READ,
        SCAN_SHIFT
    } scan_e;

    // reset release
    logic [1:0] rst_sync_q;
    logic       rst_n;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rst_sync_q <= 2'h0;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_q[1];

    // host pins: three stages, a change counts once stages two and three agree
    host_pins_s pins_s1_q;
    host_pins_s pins_s2_q;
    host_pins_s pins_s3_q;
    host_pins_s pins_q;
    host_pins_s pins_prev_q;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pins_s1_q   <= '0;
            pins_s2_q   <= '0;
            pins_s3_q   <= '0;
            pins_q      <= '0;
            pins_prev_q <= '0;
        end else begin
            pins_s1_q   <= host_in;
            pins_s2_q   <= pins_s1_q;
            pins_s3_q   <= pins_s2_q;
            pins_prev_q <= pins_q;
            if (pins_s2_q == pins_s3_q) begin
                pins_q <= pins_s3_q;
            end
        end
    end

    // strobe phases: write is strobe high with write select low, read the reverse
    logic write_now;
    logic write_was;
    logic read_now;
    logic read_was;
    logic write_end;
    logic read_end;
    logic cmd_write;
    logic data_write;
    logic data_read_end;
    logic [7:0] bus_byte;

    assign write_now     = pins_q.chip_enable & pins_q.enable_read_strobe & ~pins_q.read_write_select;
    assign write_was     = pins_prev_q.chip_enable & pins_prev_q.enable_read_strobe
                           & ~pins_prev_q.read_write_select;
    assign read_now      = pins_q.chip_enable & ~pins_q.enable_read_strobe & pins_q.read_write_select;
    assign read_was      = pins_prev_q.chip_enable & ~pins_prev_q.enable_read_strobe
                           & pins_prev_q.read_write_select;
    // data sampled while the strobe was still active, so hold time is not needed
    assign bus_byte      = pins_prev_q.data;
    assign write_end     = write_was & ~write_now;
    assign read_end      = read_was & ~read_now;
    assign cmd_write     = write_end & ~pins_prev_q.command_data_select; // R1
    assign data_write    = write_end & pins_prev_q.command_data_select;
    assign data_read_end = read_end & pins_prev_q.command_data_select;

    // command decode
    logic is_start;
    logic is_page;
    logic is_column;
    logic is_map;
    logic is_static;
    logic is_duty;
    logic is_display;
    logic column_legal;

    assign is_start     = cmd_write & ((bus_byte & START_MASK) == START_CODE);      // R4
    assign is_page      = cmd_write & ((bus_byte & PAGE_MASK) == PAGE_CODE);        // R7
    assign column_legal = bus_byte[6:0] <= LAST_COLUMN;                             // R10
    assign is_column    = cmd_write & ((bus_byte & COLUMN_MASK) == COLUMN_CODE) & column_legal; // R10
    assign is_map       = cmd_write & ((bus_byte & ONE_BIT_MASK) == MAP_CODE);      // R12
    assign is_static    = cmd_write & ((bus_byte & ONE_BIT_MASK) == STATIC_CODE);   // R15
    assign is_duty      = cmd_write & ((bus_byte & ONE_BIT_MASK) == DUTY_CODE);     // R18
    assign is_display   = cmd_write & ((bus_byte & ONE_BIT_MASK) == DISPLAY_CODE);

    // configuration registers
    config_s    cfg_q;
    config_s    cfg_d;
    logic [6:0] column_next;
    logic       column_step;

    assign column_step = data_write | data_read_end; // R21
    assign column_next = (cfg_q.memory_column_pointer == LAST_COLUMN) ? 7'h00 // R9
                         : cfg_q.memory_column_pointer + 7'h01;               // R8

    always_comb begin
        // anything not decoded falls through unchanged
        cfg_d = cfg_q; // R20
        if (is_start) begin
            cfg_d.first_row_pointer = bus_byte[4:0]; // R4
        end
        if (is_page) begin
            cfg_d.memory_page_pointer = bus_byte[1:0]; // R7
        end
        if (is_column) begin
            cfg_d.memory_column_pointer = bus_byte[6:0]; // R10
        end else if (column_step) begin
            cfg_d.memory_column_pointer = column_next; // R8
        end
        if (is_map) begin
            cfg_d.segment_order_select = bus_byte[0]; // R12
        end
        if (is_static) begin
            cfg_d.low_power_hold = bus_byte[0]; // R15
        end
        if (is_duty) begin
            cfg_d.duty_32 = bus_byte[0]; // R18
        end
        if (is_display) begin
            cfg_d.display_on = bus_byte[0];
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cfg_q <= '{START_RST, PAGE_RST, COLUMN_RST, MAP_RST, STATIC_RST, DUTY_RST, DISPLAY_RST};
        end else begin
            cfg_q <= cfg_d;
        end
    end

    // status flags
    // busy only informs the host; accesses during busy are still taken
    logic       busy_q;
    logic       resetting_q;
    logic [7:0] status_byte;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            busy_q      <= 1'b1;
            resetting_q <= 1'b1;
        end else begin
            resetting_q <= 1'b0;
            busy_q      <= write_end | read_end;
        end
    end

    always_comb begin
        status_byte               = 8'h00; // R19
        status_byte[ST_BUSY_BIT]  = busy_q | resetting_q;
        status_byte[ST_MAP_BIT]   = cfg_q.segment_order_select;
        status_byte[ST_OFF_BIT]   = ~cfg_q.display_on;
        status_byte[ST_RESET_BIT] = resetting_q;
    end

    // display memory, host port on the page and column pointers
    logic [7:0] host_rdata;
    logic [7:0] scan_rdata;
    logic [1:0] scan_page;
    logic [6:0] scan_column;

    display_ram u_ram (
        .clk      (clk),
        .a_page   (cfg_q.memory_page_pointer), // R5
        .a_column (cfg_q.memory_column_pointer),
        .a_write  (data_write),
        .a_wdata  (bus_byte),
        .a_rdata  (host_rdata),
        .b_page   (scan_page),
        .b_column (scan_column),
        .b_rdata  (scan_rdata)
    );

    // read data out of a flop, bus driven only while a read strobe is held
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            data_out <= 8'h00;
        end else begin
            data_out <= pins_q.command_data_select ? host_rdata : status_byte; // R19
        end
    end
    assign data_oe = read_now;

    // row clock: the divider freezes in hold, which stops all scanning
    logic [11:0] tick_cnt_q;
    logic        row_tick;
    logic        scan_run;
    logic        osc_q;

    assign scan_run = ~cfg_q.low_power_hold; // R13
    assign row_tick = scan_run & (tick_cnt_q == ROW_TICK_CYCLES - 12'h001);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tick_cnt_q <= 12'h000;
            osc_q      <= 1'b0;
        end else if (scan_run) begin // R13
            tick_cnt_q <= row_tick ? 12'h000 : tick_cnt_q + 12'h001;
            if (row_tick) begin
                osc_q <= ~osc_q;
            end
        end
    end

    // oscillator pin floats while held
    assign oscillator_output_pin = osc_q;
    assign oscillator_output_oe  = scan_run; // R13
    assign low_power_active      = cfg_q.low_power_hold;

    // row scan
    scan_e                  scan_q;
    logic [3:0]             com_idx_q;
    logic [6:0]             seg_idx_q;
    logic [NUM_COLUMNS-1:0] seg_buf_q;
    logic [4:0]             row_sum;
    logic [4:0]             scan_row;
    logic                   scan_bit;
    logic [NUM_COLUMNS-1:0] row_bits;

    // 16 row duty wraps inside the half the start row lies in
    assign row_sum  = 5'(cfg_q.first_row_pointer + {1'b0, com_idx_q});             // R3
    assign scan_row = cfg_q.duty_32 ? row_sum                                      // R18
                      : {cfg_q.first_row_pointer[4], row_sum[3:0]};                // R3
    assign scan_page   = scan_row[4:3];                                            // R5
    assign scan_column = cfg_q.segment_order_select ? LAST_COLUMN - seg_idx_q      // R11
                         : seg_idx_q;                                              // R11

    // the bit being shifted joins the buffer here, so the latch sees the whole row
    assign scan_bit = scan_rdata[scan_row[2:0]]; // R2
    for (genvar i = 0; i < NUM_COLUMNS; i++) begin : g_row_bit
        assign row_bits[i] = (seg_idx_q == 7'(i)) ? scan_bit : seg_buf_q[i];
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            scan_q    <= SCAN_WAIT;
            seg_idx_q <= 7'h00;
            seg_buf_q <= '0;
        end else if (scan_run) begin // R13
            unique case (scan_q)
                SCAN_WAIT: begin
                    seg_idx_q <= 7'h00;
                    if (row_tick) begin
                        scan_q <= SCAN_READ;
                    end
                end
                SCAN_READ: begin
                    scan_q <= SCAN_SHIFT;
                end
                SCAN_SHIFT: begin
                    seg_buf_q <= row_bits; // R2
                    if (seg_idx_q == LAST_COLUMN) begin
                        scan_q <= SCAN_WAIT;
                    end else begin
                        seg_idx_q <= seg_idx_q + 7'h01;
                        scan_q    <= SCAN_READ;
                    end
                end
                default: begin
                    // the spare state code falls back to idle
                    scan_q <= SCAN_WAIT;
                end
            endcase
        end
    end

    // latch a finished row onto the drivers; only sixteen commons exist here
    logic                   row_done;
    logic [NUM_COMMONS-1:0] com_q;
    logic [NUM_COLUMNS-1:0] seg_q;

    assign row_done = scan_run & (scan_q == SCAN_SHIFT) & (seg_idx_q == LAST_COLUMN);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            com_q     <= '0;
            com_idx_q <= 4'h0;
        end else if (row_done) begin
            com_q     <= NUM_COMMONS'(1) << com_idx_q; // R17
            com_idx_q <= com_idx_q + 4'h1;             // R17
        end
    end

    // one process owns the common index, so the scan never races it
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            seg_q <= '0;
        end else if (row_done) begin
            seg_q <= row_bits;
        end
    end

    // blanking: display off forces supply level, registers and memory untouched
    assign outputs_at_supply = ~cfg_q.display_on;                                // R14
    assign common_out        = cfg_q.display_on ? com_q : '0;                    // R14
    assign segment_out       = cfg_q.display_on ? seg_q : '0;                    // R14

endmodule

// ===== tb/host_model.sv
`timescale 1ns/1ps
module host_model
    import lcd_pkg::*;
(
    input  wire logic       clk,
    input  wire logic [7:0] data_out,
    input  wire logic       data_oe,
    output host_pins_s      host_in
);
    initial host_in = {1'b0, 1'b0, 1'b1, 1'b1, 8'h00};

    task automatic wr(input logic cd, input logic [7:0] b);
        @(posedge clk);
        host_in <= {1'b1, cd, 1'b1, 1'b0, b};
        repeat (6) @(posedge clk);
        host_in.read_write_select <= 1'b1;
        repeat (3) @(posedge clk);
        // released lines show the inverse, not a kind stale value
        host_in <= {1'b0, cd, 1'b1, 1'b1, ~b};
        repeat (6) @(posedge clk);
        #1;
    endtask

    task automatic rd(input logic cd, output logic [7:0] b);
        int n;
        n = 0;
        @(posedge clk);
        host_in <= {1'b1, cd, 1'b0, 1'b1, host_in.data};
        do begin
            @(posedge clk) #1;
            n++;
        end while (data_oe !== 1'b1 && n < 20);
        @(posedge clk) #1;
        b = data_out;
        @(posedge clk);
        host_in.enable_read_strobe <= 1'b1;
        repeat (8) @(posedge clk);
        host_in.chip_enable <= 1'b0;
        repeat (2) @(posedge clk);
        #1;
    endtask
endmodule

// ===== tb/lcd_decoder_asserts.sv
`timescale 1ns/1ps
module lcd_decoder_checker
    import lcd_pkg::*;
(
    input wire logic                   clk,
    input wire logic                   rst_b,
    input wire host_pins_s             host_in,
    input wire logic [7:0]             data_out,
    input wire logic                   data_oe,
    input wire logic [NUM_COMMONS-1:0] common_out,
    input wire logic [NUM_COLUMNS-1:0] segment_out,
    input wire logic                   outputs_at_supply,
    input wire logic                   oscillator_output_pin,
    input wire logic                   oscillator_output_oe,
    input wire logic                   low_power_active
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);
    logic                   wr_pin;
    logic                   rd_pin;
    logic [3:0]             quiet_d;
    logic [3:0]             quiet_q;
    logic [NUM_COMMONS-1:0] com_q;
    assign wr_pin  = host_in.chip_enable & host_in.enable_read_strobe & ~host_in.read_write_select;
    assign rd_pin  = host_in.chip_enable & ~host_in.enable_read_strobe & host_in.read_write_select;
    // pins are async, so only long quiet spans are judged
    assign quiet_d = wr_pin ? 4'h0 : quiet_q + {3'h0, ~&quiet_q};
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            quiet_q <= 4'h0;
            com_q   <= '0;
        end else begin
            quiet_q <= quiet_d;
            com_q   <= common_out;
        end
    end

    property p_onehot; $onehot0(common_out); endproperty
    a_onehot: assert property (p_onehot) else $error("several commons driven");
    property p_supply;
        outputs_at_supply && $past(outputs_at_supply) |-> common_out == '0 && segment_out == '0;
    endproperty
    a_supply: assert property (p_supply) else $error("drive not at supply");
    property p_osc_oe; oscillator_output_oe == !low_power_active; endproperty
    a_osc_oe: assert property (p_osc_oe) else $error("oscillator enable wrong");
    property p_freeze;
        low_power_active && $past(low_power_active, 2) |-> $stable(common_out) && $stable(oscillator_output_pin);
    endproperty
    a_freeze: assert property (p_freeze) else $error("logic switched in hold");
    property p_status; data_oe && $past(data_oe) && !host_in.command_data_select |-> data_out[3:0] == 4'h0; endproperty
    a_status: assert property (p_status) else $error("status low nibble set");
    property p_quiet; quiet_q == 4'hF |-> $stable(low_power_active) && $stable(outputs_at_supply); endproperty
    a_quiet: assert property (p_quiet) else $error("state moved without write");
    property p_oe_off; !rd_pin [*5] |-> !data_oe; endproperty
    a_oe_off: assert property (p_oe_off) else $error("bus driven without read");
    property p_scan;
        common_out != com_q && common_out != '0 && com_q != '0 |->
            common_out == {com_q[NUM_COMMONS-2:0], com_q[NUM_COMMONS-1]};
    endproperty
    a_scan: assert property (p_scan) else $error("common skipped");
    c_status: cover property (data_oe && !host_in.command_data_select);
    c_hold: cover property ($rose(low_power_active));
    c_wrap: cover property (com_q[NUM_COMMONS-1] && common_out[0]);
endmodule

bind lcd_addressing_command_decoder lcd_decoder_checker u_chk (
    .clk(clk), .rst_b(rst_b), .host_in(host_in), .data_out(data_out), .data_oe(data_oe),
    .common_out(common_out), .segment_out(segment_out), .outputs_at_supply(outputs_at_supply),
    .oscillator_output_pin(oscillator_output_pin), .oscillator_output_oe(oscillator_output_oe),
    .low_power_active(low_power_active)
);

// ===== tb/lcd_addressing_command_decoder_tb.sv
`timescale 1ns/1ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin miscompares++; \
    $display("CHECK FAILED at %0t got %h expected %h", $time, g, e); end end
module lcd_addressing_command_decoder_tb
    import lcd_pkg::*;
();
    logic                   clk = 1'b0;
    logic                   rst_b = 1'b0;
    host_pins_s             host_in;
    logic [7:0]             data_out;
    logic                   data_oe;
    logic [NUM_COMMONS-1:0] common_out;
    logic [NUM_COLUMNS-1:0] segment_out;
    logic                   outputs_at_supply;
    logic                   osc_pin;
    logic                   osc_oe;
    logic                   low_power_active;
    int                     miscompares = 0;
    int                     n_compared = 0;
    int                     seed = 32'hBB5A;
    logic [7:0]             mem [4][8];
    logic [7:0]             x;
    logic [NUM_COMMONS-1:0] frozen;

    always #2 clk = ~clk;

    lcd_addressing_command_decoder uut (.clk(clk), .rst_b(rst_b), .host_in(host_in), .data_out(data_out),
        .data_oe(data_oe), .common_out(common_out), .segment_out(segment_out),
        .outputs_at_supply(outputs_at_supply), .oscillator_output_pin(osc_pin),
        .oscillator_output_oe(osc_oe), .low_power_active(low_power_active));
    host_model host (.clk(clk), .data_out(data_out), .data_oe(data_oe), .host_in(host_in));

    task automatic cmd(input logic [7:0] b);
        host.wr(1'b0, b);
    endtask
    task automatic dat(input logic [7:0] b);
        host.wr(1'b1, b);
    endtask
    task automatic rd_chk(input logic cd, input logic [7:0] e);
        logic [7:0] g;
        host.rd(cd, g);
        `CHK(g, e)
    endtask
    task automatic wait_com(input logic [NUM_COMMONS-1:0] v);
        int n;
        n = 0;
        while (common_out !== v && n < 20000) begin
            @(posedge clk) #1;
            n++;
        end
        `CHK(common_out, v)
    endtask
    // expected first eight columns for the row on common k
    function automatic logic [7:0] row_exp(input logic [4:0] s, input logic [3:0] k, input logic d32);
        logic [4:0] r;
        logic [7:0] e;
        r = d32 ? s + {1'b0, k} : {s[4], s[3:0] + k};
        for (int i = 0; i < 8; i++) e[i] = mem[r[4:3]][i][r[2:0]];
        return e;
    endfunction
    task automatic scan_chk(input logic [4:0] s, input logic d32, input logic m);
        logic [7:0] g;
        // common 14 first: a row for common 0 may be building already
        wait_com(16'h4000);
        wait_com(16'h8000);
        for (int k = 0; k < 4; k++) begin
            wait_com(16'h0001 << k);
            for (int i = 0; i < 8; i++) g[i] = m ? segment_out[79 - i] : segment_out[i];
            `CHK(g, row_exp(s, k[3:0], d32))
        end
    endtask
    task automatic complete_run();
        $display("compared %0d mismatched %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    initial begin
        repeat (100000) @(posedge clk);
        miscompares++;
        complete_run();
    end

    initial begin
        repeat (16) @(posedge clk);
        rst_b <= 1'b1;
        repeat (8) @(posedge clk);
        rd_chk(1'b0, 8'h20);
        for (int m = 1; m >= 0; m--) begin
            cmd(8'hA0 | 8'(m));
            rd_chk(1'b0, {1'b0, m[0], 6'h20});
        end
        for (int p = 0; p < 4; p++) begin
            cmd(8'hB8 | 8'(p));
            cmd(8'h00);
            for (int c = 0; c < 8; c++) begin
                mem[p][c] = 8'($random(seed));
                dat(mem[p][c]);
            end
        end
        for (int p = 3; p >= 0; p--) begin
            cmd(8'hB8 | 8'(p));
            cmd(8'h00);
            for (int c = 0; c < 8; c++) rd_chk(1'b1, mem[p][c]);
        end
        x = 8'($random(seed));
        cmd(8'h4F);
        dat(x);
        dat(8'hA5);
        mem[0][0] = 8'hA5;
        cmd(8'h4F);
        rd_chk(1'b1, x);
        rd_chk(1'b1, 8'hA5);
        cmd(8'h05);
        cmd(8'h50);
        cmd(8'hE5);
        rd_chk(1'b0, 8'h20);
        dat(~x);
        mem[0][5] = ~x;
        cmd(8'h05);
        rd_chk(1'b1, ~x);
        cmd(8'hAF);
        rd_chk(1'b0, 8'h00);
        cmd(8'hDF);
        scan_chk(5'h1F, 1'b1, 1'b0);
        cmd(8'hA8);
        cmd(8'hA1);
        cmd(8'hDD);
        scan_chk(5'h1D, 1'b0, 1'b1);
        cmd(8'hA5);
        `CHK(low_power_active, 1'b1)
        `CHK(osc_oe, 1'b0)
        frozen = common_out;
        repeat (3000) @(posedge clk);
        #1;
        `CHK(common_out, frozen)
        cmd(8'hA4);
        `CHK(low_power_active, 1'b0)
        wait_com(16'h0001);
        cmd(8'hAE);
        cmd(8'hA5);
        `CHK(outputs_at_supply, 1'b1)
        `CHK(common_out, 16'h0000)
        cmd(8'hA4);
        cmd(8'hAF);
        cmd(8'hBB);
        cmd(8'h02);
        rd_chk(1'b1, mem[3][2]);
        complete_run();
    end
endmodule
